//--- sar_pkg.sv
// Purpose: Shared constants and types for the converter sequencer
// Assumes: One 10 MHz clock, synchronous active-high reset
// Notes:   Temperature scaling constants are plain defaults
package sar_pkg;
	// ----------------------------------------
	// Converter core
	// ----------------------------------------
	localparam int         ADC_BITS   = 10;
	localparam int         NUM_ADC    = 3;
	localparam logic [3:0] ACQ_CYC    = 4'h4;   // Sampling window length
	localparam logic [3:0] MSB_INDEX  = 4'h9;
	localparam logic [9:0] MSB_TRIAL  = 10'h200;
	localparam logic [3:0] BIT_PERIODS = 4'hA;

	// ----------------------------------------
	// Sequencing and storage
	// ----------------------------------------
	localparam int         NUM_VCH     = 8;
	localparam logic [2:0] LAST_VCH    = 3'h7;
	localparam logic [1:0] LAST_TSTEP  = 2'h3;  // Local, then three differences
	localparam logic [3:0] AVG_LAST    = 4'hF;  // 16 results per averaged update
	localparam logic [4:0] ADDR_LOCAL  = 5'h10;
	localparam logic [4:0] ADDR_REMOTE = 5'h11;
	localparam logic [1:0] MULT_BASE   = 2'h0;  // Base diode current

	// ----------------------------------------
	// Temperature arithmetic
	// ----------------------------------------
	localparam logic [9:0] TEMP_ZERO   = 10'h200; // Code taken as 0 degrees
	localparam logic [4:0] W_D1        = 5'h13;   // Weights cancelling series R
	localparam logic [4:0] W_D2        = 5'h04;
	localparam logic [4:0] W_D3        = 5'h01;
	localparam int         CANCEL_SHIFT = 3;

	typedef enum logic [1:0] {S_IDLE, S_ACQ, S_PH1, S_PH2} sar_state_t;
endpackage : sar_pkg

//--- sar_core.sv
// Purpose: One successive-approximation converter control
// Assumes: Comparator output synchronous, valid in the second phase
// Notes:   One bit decided per phi1/phi2 pair
`timescale 1ns/1ps
`default_nettype none
module sar_core (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       start_i,
	input  wire logic       cmp_i,
	output logic            sample_o,
	output logic            phi1_o,
	output logic            phi2_o,
	output logic            busy_o,
	output logic            done_o,
	output logic [9:0]      trial_o,
	output logic [9:0]      result_o
);
	sar_pkg::sar_state_t state_q, state_d;
	logic [3:0]          bit_q;
	logic [3:0]          cnt_q;
	logic [3:0]          periods_q;

	// Sequence: sample, then phi1/phi2 per bit
	always_comb begin
		state_d = state_q;
		case (state_q)
			sar_pkg::S_IDLE: if (start_i) state_d = sar_pkg::S_ACQ;
			sar_pkg::S_ACQ:  if (cnt_q == sar_pkg::ACQ_CYC - 4'h1) state_d = sar_pkg::S_PH1;
			sar_pkg::S_PH1:  state_d = sar_pkg::S_PH2;
			sar_pkg::S_PH2:  state_d = (bit_q == 4'h0) ? sar_pkg::S_IDLE : sar_pkg::S_PH1;
			default:         state_d = sar_pkg::S_IDLE;
		endcase
	end

	// Switch controls registered from next state, so phases never overlap
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_q  <= sar_pkg::S_IDLE;
			sample_o <= 1'b0;
			phi1_o   <= 1'b0;
			phi2_o   <= 1'b0;
			busy_o   <= 1'b0;
		end else begin
			state_q  <= state_d;
			sample_o <= (state_d == sar_pkg::S_ACQ);
			phi1_o   <= (state_d == sar_pkg::S_PH1);
			phi2_o   <= (state_d == sar_pkg::S_PH2);
			busy_o   <= (state_d != sar_pkg::S_IDLE);
		end
	end

	// Acquisition length counter
	always_ff @(posedge clk_i) begin
		if (reset_i || state_q != sar_pkg::S_ACQ) cnt_q <= 4'h0;
		else cnt_q <= cnt_q + 4'h1;
	end

	// Approximation register
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			trial_o  <= 10'h000;
			result_o <= 10'h000;
			bit_q    <= 4'h0;
			done_o   <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (state_q == sar_pkg::S_ACQ && state_d == sar_pkg::S_PH1) begin
				trial_o <= sar_pkg::MSB_TRIAL;
				bit_q   <= sar_pkg::MSB_INDEX;
			end else if (state_q == sar_pkg::S_PH2) begin
				trial_o[bit_q] <= cmp_i;
				if (bit_q != 4'h0) begin
					trial_o[4'(bit_q - 4'h1)] <= 1'b1;
					bit_q <= bit_q - 4'h1;
				end else begin
					result_o <= {trial_o[9:1], cmp_i};
					done_o   <= 1'b1;
				end
			end
		end
	end

	// Helper: bit periods seen in one conversion
	always_ff @(posedge clk_i) begin
		if (reset_i || sample_o) periods_q <= 4'h0;
		else if (state_q == sar_pkg::S_PH2) periods_q <= periods_q + 4'h1;
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);

	a_ten_periods: assert property (done_o |-> periods_q == sar_pkg::BIT_PERIODS)
		else $error("conversion did not take ten bit periods");
	a_msb_first: assert property (state_q == sar_pkg::S_ACQ && state_d == sar_pkg::S_PH1
		|=> trial_o == sar_pkg::MSB_TRIAL)
		else $error("first trial is not MSB only");
	a_bit_keep: assert property (state_q == sar_pkg::S_PH2
		|=> trial_o[$past(bit_q)] == $past(cmp_i))
		else $error("decided bit does not follow comparator");
	a_next_trial: assert property (state_q == sar_pkg::S_PH2 && bit_q != 4'h0
		|=> trial_o[bit_q] && bit_q == $past(bit_q) - 4'h1)
		else $error("next lower bit not set as trial");
	a_phase_gap: assert property (!(phi1_o && phi2_o) && !(sample_o && (phi1_o || phi2_o)))
		else $error("switch phases overlap");
	a_sample_open: assert property ($fell(sample_o) |-> phi1_o ##1 phi2_o)
		else $error("sampling not followed by phase one");
endmodule : sar_core
`default_nettype wire

//--- sar_monitor_sequencer.sv
// Purpose: Three-converter round-robin monitor sequencer
// Assumes: Analog front end answers on cmp_i within each phi2 cycle
// Notes:   Results readable through a registered read port
`timescale 1ns/1ps
`default_nettype none
module sar_monitor_sequencer (
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	input  wire logic [2:0]       cmp_i,
	input  wire logic             avg_en_i,
	input  wire logic [4:0]       rd_addr_i,
	output logic [2:0]            sample_o,
	output logic [2:0]            phi1_o,
	output logic [2:0]            phi2_o,
	output logic [2:0][9:0]       trial_o,
	output logic [2:0]            first_voltage_converter_sel_o,
	output logic [2:0]            second_voltage_converter_sel_o,
	output logic                  temp_remote_o,
	output logic [1:0]            diode_mult_o,
	output logic [9:0]            rd_data_o
);
	// ----------------------------------------
	// Converter cores
	// ----------------------------------------
	logic [2:0]       start_q;
	logic [2:0]       busy;
	logic [2:0]       done;
	logic [2:0][9:0]  result;

	// One core per converter; three in all
	genvar g;
	generate
		for (g = 0; g < sar_pkg::NUM_ADC; g++) begin : g_core
			sar_core u_core (
				.clk_i    (clk_i),
				.reset_i  (reset_i),
				.start_i  (start_q[g]),
				.cmp_i    (cmp_i[g]),
				.sample_o (sample_o[g]),
				.phi1_o   (phi1_o[g]),
				.phi2_o   (phi2_o[g]),
				.busy_o   (busy[g]),
				.done_o   (done[g]),
				.trial_o  (trial_o[g]),
				.result_o (result[g])
			);
		end
	endgenerate

	// Restart each core one idle cycle after it ends, so the voltage channel selects settle first
	always_ff @(posedge clk_i) begin
		if (reset_i) start_q <= 3'h0;
		else start_q <= ~busy & ~start_q;
	end

	// ----------------------------------------
	// Voltage round robins
	// ----------------------------------------
	logic [1:0][2:0]  ch_q;
	logic [9:0]       res_q [2*sar_pkg::NUM_VCH];

	genvar v;
	generate
		for (v = 0; v < 2; v++) begin : g_volt
			// Each sequence steps on its own converter's completion only
			always_ff @(posedge clk_i) begin
				if (reset_i) ch_q[v] <= 3'h0;
				else if (done[v]) ch_q[v] <= ch_q[v] + 3'h1;
			end
		end
	endgenerate

	// Both sequences share one store; a single writing process keeps one driver
	always_ff @(posedge clk_i) begin
		if (done[0]) res_q[{1'b0, ch_q[0]}] <= result[0];
		if (done[1]) res_q[{1'b1, ch_q[1]}] <= result[1];
	end

	assign first_voltage_converter_sel_o  = ch_q[0];
	assign second_voltage_converter_sel_o = ch_q[1];

	// ----------------------------------------
	// Temperature sequence
	// ----------------------------------------
	logic [1:0]         tstep_q;
	logic [3:1][9:0]    delta_q;
	logic               chop_q;
	logic signed [16:0] cancel;
	logic signed [9:0]  t_new;
	logic               t_valid;
	logic               t_idx;

	// Step 0 local, steps 1..3 remote differences at multiples 1..3
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			tstep_q <= 2'h0;
			delta_q <= '0;
		end else if (done[2]) begin
			tstep_q <= (tstep_q == sar_pkg::LAST_TSTEP) ? 2'h0 : tstep_q + 2'h1;
			if (tstep_q != 2'h0) delta_q[tstep_q] <= result[2];
		end
	end

	// Diode current toggles base versus the step's multiple
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			chop_q        <= 1'b0;
			diode_mult_o  <= sar_pkg::MULT_BASE;
			temp_remote_o <= 1'b0;
		end else begin
			chop_q        <= ~chop_q;
			temp_remote_o <= (tstep_q != 2'h0);
			diode_mult_o  <= (tstep_q != 2'h0 && chop_q) ? tstep_q : sar_pkg::MULT_BASE;
		end
	end

	// Weighted differences drop the resistive term; no trim needed
	always_comb begin
		cancel = 17'(signed'({7'h00, sar_pkg::W_D1}) * signed'({7'h00, delta_q[1]}))
		       - 17'(signed'({7'h00, sar_pkg::W_D2}) * signed'({7'h00, delta_q[2]}))
		       - 17'(signed'({7'h00, sar_pkg::W_D3}) * signed'({7'h00, result[2]}));
		t_valid = done[2] && (tstep_q == 2'h0 || tstep_q == sar_pkg::LAST_TSTEP);
		t_idx   = (tstep_q != 2'h0);
		if (t_idx) t_new = 10'(cancel >>> sar_pkg::CANCEL_SHIFT) - sar_pkg::TEMP_ZERO;
		else t_new = result[2] - sar_pkg::TEMP_ZERO;
	end

	// ----------------------------------------
	// Temperature registers with averaging
	// ----------------------------------------
	logic [1:0][9:0]          temp_q;
	logic signed [1:0][13:0]  acc_q;
	logic [1:0][3:0]          avg_cnt_q;

	genvar j;
	generate
		for (j = 0; j < 2; j++) begin : g_temp
			// Old value stays until a fresh or averaged result is ready
			always_ff @(posedge clk_i) begin
				if (reset_i) begin
					temp_q[j]    <= 10'h000;
					acc_q[j]     <= 14'h0000;
					avg_cnt_q[j] <= 4'h0;
				end else if (t_valid && t_idx == 1'(j)) begin
					if (!avg_en_i) begin
						temp_q[j]    <= t_new;
						acc_q[j]     <= 14'h0000;
						avg_cnt_q[j] <= 4'h0;
					end else begin
						avg_cnt_q[j] <= avg_cnt_q[j] + 4'h1;
						if (avg_cnt_q[j] == sar_pkg::AVG_LAST) begin
							temp_q[j] <= 10'((acc_q[j] + 14'(t_new)) >>> 4);
							acc_q[j]  <= 14'h0000;
						end else acc_q[j] <= acc_q[j] + 14'(t_new);
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Read port toward the serial interface
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) rd_data_o <= 10'h000;
		else if (rd_addr_i == sar_pkg::ADDR_LOCAL) rd_data_o <= temp_q[0];
		else if (rd_addr_i == sar_pkg::ADDR_REMOTE) rd_data_o <= temp_q[1];
		else if (!rd_addr_i[4]) rd_data_o <= res_q[rd_addr_i[3:0]];
		else rd_data_o <= 10'h000;   // Unmapped reads as zero
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);

	a_rr_first: assert property (done[0] |=> ch_q[0] == $past(ch_q[0]) + 3'h1)
		else $error("first sequence did not advance");
	a_rr_second: assert property (!done[1] |=> $stable(ch_q[1]))
		else $error("second sequence moved without its converter");
	a_rr_wrap: assert property (done[1] && ch_q[1] == sar_pkg::LAST_VCH |=> ch_q[1] == 3'h0)
		else $error("sequence did not wrap to first channel");
	a_result_store: assert property (done[0] |=> res_q[$past(ch_q[0])] == $past(result[0]))
		else $error("result not stored for its channel");
	a_read_temp: assert property (rd_addr_i == sar_pkg::ADDR_LOCAL |=> rd_data_o == $past(temp_q[0]))
		else $error("local temperature not returned on read");
	a_temp_hold: assert property (!t_valid |=> $stable(temp_q))
		else $error("temperature changed without a valid result");
	a_local_base: assert property (tstep_q == 2'h0 ##1 tstep_q == 2'h0
		|-> diode_mult_o == sar_pkg::MULT_BASE && !temp_remote_o)
		else $error("diode current not at base during local step");
	a_shared_conv: assert property (done[2] && tstep_q == sar_pkg::LAST_TSTEP |=> tstep_q == 2'h0)
		else $error("temperature step order broken");

	// Second store, first wrap, register update, chopping and read rules
	a_store_second: assert property (done[1]
		|=> res_q[{1'b1, $past(ch_q[1])}] == $past(result[1]))
		else $error("second sequence result not stored for its channel");
	a_wrap_first: assert property (done[0] && ch_q[0] == sar_pkg::LAST_VCH
		|=> ch_q[0] == 3'h0)
		else $error("first sequence did not wrap to first channel");
	a_temp_direct: assert property (t_valid && !avg_en_i && !t_idx
		|=> temp_q[0] == $past(t_new))
		else $error("local temperature not updated with a fresh result");
	a_avg_hold: assert property (t_valid && avg_en_i && !t_idx
		&& avg_cnt_q[0] != sar_pkg::AVG_LAST |=> $stable(temp_q[0]))
		else $error("averaged temperature updated before sixteen rounds");
	a_diode_chop: assert property (temp_remote_o && diode_mult_o != sar_pkg::MULT_BASE
		|=> diode_mult_o == sar_pkg::MULT_BASE)
		else $error("diode current did not return to base");
	a_read_first: assert property (rd_addr_i == 5'h00 |=> rd_data_o == $past(res_q[0]))
		else $error("first input result not returned on read");
endmodule : sar_monitor_sequencer
`default_nettype wire

//--- analog_front_model.sv
// Purpose: Behavioural analog front end facing the three converters
// Assumes: Each channel sits at a fixed code; comparator high when input >= DAC
// Notes:   Outside phi2 the comparator wanders so a misplaced sample shows
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
	input  wire logic            clk_i,
	input  wire logic [2:0]      phi2_i,
	input  wire logic [2:0][9:0] trial_i,
	input  wire logic [2:0]      sel_a_i,
	input  wire logic [2:0]      sel_b_i,
	input  wire logic            remote_i,
	input  wire logic [9:0]      local_code_i,
	output logic      [2:0]      cmp_o
);
	// ----------------------------------------
	// Input levels and comparator
	// ----------------------------------------
	logic [2:0][9:0] level;
	logic [2:0]      wander_q = 3'h5;

	// Distinct code per channel; remote differences all equal
	always_comb begin
		level[0] = {sel_a_i, 7'h15};
		level[1] = {~sel_b_i, 7'h2A};
		level[2] = remote_i ? 10'h160 : local_code_i;
		for (int i = 0; i < 3; i++) begin
			cmp_o[i] = phi2_i[i] ? (trial_i[i] <= level[i]) : wander_q[i];
		end
	end

	// Changes every cycle: the design must not look outside phi2
	always_ff @(posedge clk_i) begin
		wander_q <= ~wander_q;
	end
endmodule : analog_front_model
`default_nettype wire

//--- sar_monitor_sequencer_bench.sv
// Purpose: Self-checking bench for the three-converter sequencer
// Assumes: Front end model answers every comparison
// Notes:   Averaging test runs last; it is the longest
`timescale 1ns/1ps
`default_nettype none
module sar_monitor_sequencer_bench;
	localparam time DLY = 1ns;
	localparam int  D_REM = 352; // Remote difference level of the model
	logic clk = 1'b0, reset = 1'b1, avg_en = 1'b0;
	logic [4:0] rd_addr = 5'h00;
	logic [9:0] local_code = 10'h264;
	logic [2:0] cmp, sample, phi1, phi2, sel_a, sel_b;
	logic [2:0][9:0] trial;
	logic temp_remote;
	logic [1:0] diode_mult;
	logic [9:0] rd_data, word;
	int miscompares = 0, n_compared = 0, cycles = 0;

	sar_monitor_sequencer sar_monitor_sequencer_i (.clk_i(clk), .reset_i(reset), .cmp_i(cmp),
		.avg_en_i(avg_en), .rd_addr_i(rd_addr), .sample_o(sample), .phi1_o(phi1),
		.phi2_o(phi2), .trial_o(trial), .first_voltage_converter_sel_o(sel_a),
		.second_voltage_converter_sel_o(sel_b), .temp_remote_o(temp_remote),
		.diode_mult_o(diode_mult), .rd_data_o(rd_data));
	analog_front_model analog_front_model_i (.clk_i(clk), .phi2_i(phi2), .trial_i(trial),
		.sel_a_i(sel_a), .sel_b_i(sel_b), .remote_i(temp_remote),
		.local_code_i(local_code), .cmp_o(cmp));

	// ----------------------------------------
	// Clock, timeout and shared tasks
	// ----------------------------------------
	always #50 clk = ~clk;
	// Ceiling well above the roughly 6100 cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 12000) begin
			miscompares++;
			$display("Error at %0t: run did not finish", $time);
			wrap_up();
		end
	end
	task automatic step();
		@(posedge clk);
		#DLY;
	endtask : step
	task automatic compare_word(logic [9:0] got, logic [9:0] exp, string what);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : compare_word
	task automatic compare_flag(logic got, logic exp, string what);
		compare_word({9'h000, got}, {9'h000, exp}, what);
	endtask : compare_flag
	task automatic read_word(logic [4:0] addr, output logic [9:0] data);
		rd_addr = addr;
		step();
		data = rd_data;
	endtask : read_word
	task automatic wait_sample(logic lvl);
		for (int n = 0; n < 100 && sample[0] !== lvl; n++) step();
	endtask : wait_sample

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Sampling, two phases per bit, MSB-first search on one conversion
	task automatic walk_conversion();
		logic [9:0] target, exp;
		wait_sample(1'b0);
		wait_sample(1'b1);
		target = {sel_a, 7'h15};
		for (int i = 0; i < int'(sar_pkg::ACQ_CYC); i++) begin
			compare_word({7'h00, sample[0], phi1[0], phi2[0]}, 10'h004, "acq only");
			compare_flag(sample[0], 1'b1, "sample");
			step();
		end
		for (int k = 9; k >= 0; k--) begin
			exp = (target & (10'h3FF << (k + 1))) | (10'h001 << k);
			compare_word({7'h00, sample[0], phi1[0], phi2[0]}, 10'h002, "phase one");
			compare_word(trial[0], exp, "trial");
			step();
			compare_word({7'h00, sample[0], phi1[0], phi2[0]}, 10'h001, "phase two");
			step();
		end
	endtask : walk_conversion
	// Ascending wrap on both sequences, then every stored result
	task automatic channel_rounds();
		logic [2:0] pa, pb, ps;
		int rises;
		// Reset leaves both selects at the first input, so the last one precedes it
		pa = sar_pkg::LAST_VCH;
		pb = sar_pkg::LAST_VCH;
		ps = sample;
		rises = 0;
		for (int n = 0; n < 400 && rises < 9; n++) begin
			step();
			if (sample[0] && !ps[0]) begin
				compare_word({7'h00, sel_a}, {7'h00, pa + 3'h1}, "sel a");
				pa = sel_a;
				rises++;
			end
			if (sample[1] && !ps[1]) begin
				compare_word({7'h00, sel_b}, {7'h00, pb + 3'h1}, "sel b");
				pb = sel_b;
			end
			ps = sample;
		end
		compare_flag(rises == 9, 1'b1, "rounds seen");
		for (int a = 0; a < 8; a++) begin
			read_word(5'(a), word);
			compare_word(word, {3'(a), 7'h15}, "input 1-8");
			read_word(5'(a + 8), word);
			compare_word(word, {~3'(a), 7'h2A}, "input 9-16");
		end
		read_word(5'h12, word);
		compare_word(word, 10'h000, "unmapped");
	endtask : channel_rounds
	// Shared third converter, diode currents, temperature format
	task automatic temperatures();
		logic [3:0] seen;
		logic [1:0] modes;
		int w;
		seen = 4'h0;
		modes = 2'h0;
		for (int n = 0; n < 250; n++) begin
			step();
			modes[temp_remote] = 1'b1;
			if (temp_remote)
				seen[diode_mult] = 1'b1;
			else
				compare_word({8'h00, diode_mult}, 10'h000, "local current");
		end
		compare_word({6'h00, seen}, 10'h00F, "current steps");
		compare_word({8'h00, modes}, 10'h003, "shared mux");
		w = int'(sar_pkg::W_D1) - int'(sar_pkg::W_D2) - int'(sar_pkg::W_D3);
		read_word(sar_pkg::ADDR_LOCAL, word);
		compare_word(word, 10'h064, "local 25 C");
		read_word(sar_pkg::ADDR_REMOTE, word);
		compare_word(word, 10'((w * D_REM) >>> sar_pkg::CANCEL_SHIFT) - sar_pkg::TEMP_ZERO,
			"remote");
	endtask : temperatures
	// Averaged register holds until sixteen rounds have passed
	task automatic averaging();
		avg_en = 1'b1;
		local_code = 10'h274;
		repeat (330) step();
		read_word(sar_pkg::ADDR_LOCAL, word);
		compare_word(word, 10'h064, "held value");
		repeat (5200) step();
		read_word(sar_pkg::ADDR_LOCAL, word);
		compare_word(word, 10'h074, "averaged value");
	endtask : averaging

	// ----------------------------------------
	// Main sequence and verdict
	// ----------------------------------------
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (8) @(posedge clk);
		#DLY;
		compare_word({sample, phi1, phi2, 1'b0}, 10'h000, "reset outputs");
		reset = 1'b0;
		channel_rounds();
		walk_conversion();
		temperatures();
		averaging();
		wrap_up();
	end
endmodule : sar_monitor_sequencer_bench
`default_nettype wire
